// ==== hdl/dgsp_ctrl.sv ====
// Gain, sync position and polarity control bank of the video decoder.
// Assumes video timing strobes and raw internal levels from the decoder
// core on clk; all of them are synchronous to clk.
`timescale 1ns/100ps
`include "dgsp_regs.svh"
module dgsp_ctrl #(
  parameter int          CLK_HZ = `DGSP_CLK_HZ,
  parameter logic [11:0] MEAS_GAIN_INIT = 12'h400
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      clkEn,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  output logic [1:0]                     avs_response,
  input  wire logic                      intHsyncFall,
  input  wire logic                      lineStart,
  input  wire logic                      fieldStart,
  input  wire logic [9:0]                lineNum,
  input  wire logic [11:0]               measGainTarget,
  input  wire logic [11:0]               videoQuality,
  input  wire dgsp_pkg::dgsp_video_t     rawVideo,
  input  wire logic                      rawLockBit,
  output dgsp_pkg::dgsp_video_t          outVideo_ff,
  output logic                           hsyncOut_ff,
  output dgsp_pkg::dgsp_ctl_t            ctlOut_ff,
  output logic [11:0]                    gainInUse_ff
);
  logic [7:0]  modeCtl_ff;
  logic [7:0]  lumaGain1_ff;
  logic [7:0]  shadowHigh_ff;
  logic [7:0]  shadowLow_ff;
  logic [7:0]  miscGain_ff;
  logic [7:0]  hsHigh_ff;
  logic [7:0]  hsBegin_ff;
  logic [7:0]  hsEnd_ff;
  logic [7:0]  polarity_ff;
  logic [7:0]  resample_ff;
  logic        ackPend_ff;
  logic [9:0]  pixCnt_ff;
  logic        pixRun_ff;
  logic [31:0] tcCnt_ff;
  logic        tcTick;
  logic [31:0] tcLimit;
  logic        busReq;
  logic        wrStrobe;
  logic        inWindow;
  logic [9:0]  lastLine;
  logic        updEvent;
  logic [11:0] nxt_gain;
  logic [7:0]  rdByte;
  logic        mapped;
  logic [9:0]  hsBeginCnt;
  logic [9:0]  hsEndCnt;
  dgsp_pkg::dgsp_gain_mode_t gainMode;
  dgsp_pkg::dgsp_track_t     trackSel;

  function automatic logic [31:0] msToCycles(input int ms);
    longint cyc;
    cyc = longint'(CLK_HZ) * longint'(ms) / 64'd1000;
    return (cyc < 1) ? 32'd1 : cyc[31:0];
  endfunction : msToCycles

  function automatic logic [11:0] stepToward(input logic [11:0] cur,
                                             input logic [11:0] tgt);
    if (tgt > cur)
      return cur + `DGSP_GAIN_STEP_MAX;
    else if (tgt < cur)
      return cur - `DGSP_GAIN_STEP_MAX;
    else
      return cur;
  endfunction : stepToward

  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      `DGSP_OFS_GAIN_CTL1, `DGSP_OFS_LUMA_GAIN1, `DGSP_OFS_SHADOW_HIGH,
      `DGSP_OFS_SHADOW_LOW, `DGSP_OFS_MISC_GAIN, `DGSP_OFS_HS_HIGH,
      `DGSP_OFS_HS_BEGIN, `DGSP_OFS_HS_END, `DGSP_OFS_POLARITY,
      `DGSP_OFS_RESAMPLE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : isMapped

  // Register byte address is the word index on this bus
  assign busReq   = (avs_read | avs_write) & ~ackPend_ff;
  assign wrStrobe = clkEn & busReq & avs_write & avs_byteenable[0];
  assign mapped   = isMapped(avs_address);
  assign gainMode = dgsp_pkg::dgsp_gain_mode_t'(modeCtl_ff[6:4]);
  assign trackSel = dgsp_pkg::dgsp_track_t'(lumaGain1_ff[7:6]);
  assign hsBeginCnt = {hsHigh_ff[7:6], hsBegin_ff};
  assign hsEndCnt   = {hsHigh_ff[5:4], hsEnd_ff};

  // One wait cycle, then answer; every access completes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackPend_ff <= 1'b0;
    end else if (clkEn) begin
      ackPend_ff <= busReq;
    end
  end

  always_comb begin
    rdByte = 8'h00;
    case (avs_address)
      `DGSP_OFS_GAIN_CTL1:   rdByte = modeCtl_ff;
      `DGSP_OFS_LUMA_GAIN1:  rdByte = lumaGain1_ff;
      `DGSP_OFS_SHADOW_HIGH: rdByte = {shadowHigh_ff[7:4],
                                       gainInUse_ff[11:8]};
      `DGSP_OFS_SHADOW_LOW:  rdByte = gainInUse_ff[7:0];
      `DGSP_OFS_MISC_GAIN:   rdByte = miscGain_ff;
      `DGSP_OFS_HS_HIGH:     rdByte = hsHigh_ff;
      `DGSP_OFS_HS_BEGIN:    rdByte = hsBegin_ff;
      `DGSP_OFS_HS_END:      rdByte = hsEnd_ff;
      `DGSP_OFS_POLARITY:    rdByte = polarity_ff;
      `DGSP_OFS_RESAMPLE:    rdByte = resample_ff;
      default:               rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'b00;
    end else if (clkEn) begin
      avs_waitrequest <= ~busReq;
      if (busReq) begin
        avs_readdata <= avs_read ? {24'h000000, rdByte} : 32'h00000000;
        avs_response <= mapped ? 2'b00 : 2'b11;
      end
    end
  end

  // Reserved bits are stored as written; the host keeps them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeCtl_ff    <= `DGSP_RST_MODE_CTL;
      lumaGain1_ff  <= `DGSP_RST_LUMA_GAIN1;
      shadowHigh_ff <= `DGSP_RST_SHADOW_HIGH;
      shadowLow_ff  <= `DGSP_RST_SHADOW_LOW;
      miscGain_ff   <= `DGSP_RST_MISC_GAIN;
      hsHigh_ff     <= `DGSP_RST_HS_HIGH;
      hsBegin_ff    <= `DGSP_RST_HS_BEGIN;
      hsEnd_ff      <= `DGSP_RST_HS_END;
      polarity_ff   <= `DGSP_RST_POLARITY;
      resample_ff   <= `DGSP_RST_RESAMPLE;
    end else if (wrStrobe) begin
      case (avs_address)
        `DGSP_OFS_GAIN_CTL1:   modeCtl_ff    <= avs_writedata[7:0];
        `DGSP_OFS_LUMA_GAIN1:  lumaGain1_ff  <= avs_writedata[7:0];
        `DGSP_OFS_SHADOW_HIGH: shadowHigh_ff <= avs_writedata[7:0];
        `DGSP_OFS_SHADOW_LOW:  shadowLow_ff  <= avs_writedata[7:0];
        `DGSP_OFS_MISC_GAIN:   miscGain_ff   <= avs_writedata[7:0];
        `DGSP_OFS_HS_HIGH:     hsHigh_ff     <= avs_writedata[7:0];
        `DGSP_OFS_HS_BEGIN:    hsBegin_ff    <= avs_writedata[7:0];
        `DGSP_OFS_HS_END:      hsEnd_ff      <= avs_writedata[7:0];
        `DGSP_OFS_POLARITY:    polarity_ff   <= avs_writedata[7:0];
        `DGSP_OFS_RESAMPLE:    resample_ff   <= avs_writedata[7:0];
        default:               ;
      endcase
    end
  end

  // Tracking time constant as a step period
  always_comb begin
    case (trackSel)
      dgsp_pkg::TRK_SLOW:   tcLimit = msToCycles(`DGSP_TC_SLOW_MS) >> 12;
      dgsp_pkg::TRK_MEDIUM: tcLimit = msToCycles(`DGSP_TC_MED_MS) >> 12;
      dgsp_pkg::TRK_FAST:   tcLimit = msToCycles(`DGSP_TC_FAST_MS) >> 12;
      // Poorer video quality slows the loop down
      default: tcLimit = {20'h00000, videoQuality} + 32'd1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tcCnt_ff <= 32'h00000000;
    end else if (clkEn) begin
      tcCnt_ff <= tcTick ? 32'h00000000 : tcCnt_ff + 32'd1;
    end
  end
  assign tcTick = (tcCnt_ff >= tcLimit);

  assign lastLine = miscGain_ff[`DGSP_BIT_AVG_LINES] ?
                    `DGSP_AVG_LAST_SHORT : `DGSP_AVG_LAST_LONG;
  assign inWindow = (lineNum >= `DGSP_AVG_FIRST_LINE) &&
                    (lineNum <= lastLine);
  assign updEvent = miscGain_ff[`DGSP_BIT_PEAK_WHITE_UPDATE_RATE] ?
                    fieldStart : lineStart;

  always_comb begin
    nxt_gain = gainInUse_ff;
    case (gainMode)
      dgsp_pkg::LGM_MANUAL:
        nxt_gain = {shadowHigh_ff[3:0], shadowLow_ff};
      dgsp_pkg::LGM_PEAK, dgsp_pkg::LGM_AVERAGE:
        if (updEvent && inWindow)
          nxt_gain = stepToward(gainInUse_ff, measGainTarget);
      dgsp_pkg::LGM_AUTOOVR:
        if (tcTick)
          nxt_gain = stepToward(gainInUse_ff, measGainTarget);
      dgsp_pkg::LGM_FREEZE:
        nxt_gain = gainInUse_ff;
      default:
        if (updEvent)
          nxt_gain = measGainTarget;
    endcase
    // Surveillance: a store write reloads gain in automatic modes too
    if (shadowHigh_ff[`DGSP_BIT_SURV_EN] && wrStrobe &&
        avs_address == `DGSP_OFS_SHADOW_LOW)
      nxt_gain = {shadowHigh_ff[3:0], avs_writedata[7:0]};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gainInUse_ff <= MEAS_GAIN_INIT;
    end else if (clkEn) begin
      gainInUse_ff <= nxt_gain;
    end
  end

  // Hsync output placement within the line
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pixCnt_ff   <= 10'h000;
      pixRun_ff   <= 1'b0;
      hsyncOut_ff <= 1'b0;
    end else if (clkEn) begin
      if (intHsyncFall) begin
        pixCnt_ff <= 10'h000;
        pixRun_ff <= 1'b1;
      end else if (pixRun_ff) begin
        pixCnt_ff <= pixCnt_ff + 10'h001;
        if (pixCnt_ff == 10'h3ff)
          pixRun_ff <= 1'b0;
      end
      if (pixRun_ff && pixCnt_ff == hsBeginCnt)
        hsyncOut_ff <= ~polarity_ff[7];
      else if (pixRun_ff && pixCnt_ff == hsEndCnt)
        hsyncOut_ff <= polarity_ff[7];
      else if (!pixRun_ff)
        hsyncOut_ff <= polarity_ff[7];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      outVideo_ff <= '0;
    end else if (clkEn) begin
      outVideo_ff.clkOut    <= rawVideo.clkOut ^ polarity_ff[0];
      outVideo_ff.clkHalf   <= rawVideo.clkHalf ^ polarity_ff[0];
      outVideo_ff.qualClk   <= rawVideo.qualClk ^ polarity_ff[0];
      outVideo_ff.fifoHalf  <= rawVideo.fifoHalf ^ polarity_ff[1];
      outVideo_ff.fifoEmpty <= rawVideo.fifoEmpty ^ polarity_ff[1];
      outVideo_ff.fifoFull  <= rawVideo.fifoFull ^ polarity_ff[1];
      outVideo_ff.dataValid <= rawVideo.dataValid ^ polarity_ff[2];
      outVideo_ff.fieldSync <= rawVideo.fieldSync ^ polarity_ff[3];
      outVideo_ff.lineRef   <= rawVideo.lineRef ^ polarity_ff[4];
      outVideo_ff.vsync     <= rawVideo.vsync ^ polarity_ff[5];
      outVideo_ff.hrefWin   <= rawVideo.hrefWin ^ polarity_ff[6];
      outVideo_ff.vrefWin   <= rawVideo.vrefWin ^ polarity_ff[6];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctlOut_ff <= '0;
    end else if (clkEn) begin
      ctlOut_ff.measPulse <= updEvent & inWindow;
      ctlOut_ff.colorKill <= miscGain_ff[`DGSP_BIT_COLOR_KILL];
      ctlOut_ff.lockBit   <= rawLockBit ^
                             resample_ff[`DGSP_BIT_LOCK_INV];
      case (miscGain_ff[4:2])
        3'b000:  begin ctlOut_ff.ireCeilPal  <= 9'd133;
                       ctlOut_ff.ireCeilNtsc <= 9'd122; end
        3'b001:  begin ctlOut_ff.ireCeilPal  <= 9'd125;
                       ctlOut_ff.ireCeilNtsc <= 9'd115; end
        3'b010:  begin ctlOut_ff.ireCeilPal  <= 9'd120;
                       ctlOut_ff.ireCeilNtsc <= 9'd110; end
        3'b011:  begin ctlOut_ff.ireCeilPal  <= 9'd115;
                       ctlOut_ff.ireCeilNtsc <= 9'd105; end
        3'b100:  begin ctlOut_ff.ireCeilPal  <= 9'd110;
                       ctlOut_ff.ireCeilNtsc <= 9'd100; end
        3'b101:  begin ctlOut_ff.ireCeilPal  <= 9'd105;
                       ctlOut_ff.ireCeilNtsc <= 9'd100; end
        default: begin ctlOut_ff.ireCeilPal  <= 9'd100;
                       ctlOut_ff.ireCeilNtsc <= 9'd100; end
      endcase
    end
  end
endmodule : dgsp_ctrl

// ==== hdl/dgsp_regs.svh ====
// Register offsets, field positions and reset values of the gain, sync
// position and polarity control bank.
// Assumes a byte-wide register file on an Avalon-MM word bus.
`ifndef DGSP_REGS_SVH
`define DGSP_REGS_SVH
`define DGSP_ADDR_W          8
`define DGSP_OFS_GAIN_CTL1   8'h2c
`define DGSP_OFS_LUMA_GAIN1  8'h2f
`define DGSP_OFS_SHADOW_HIGH 8'h31
`define DGSP_OFS_SHADOW_LOW  8'h32
`define DGSP_OFS_MISC_GAIN   8'h33
`define DGSP_OFS_HS_HIGH     8'h34
`define DGSP_OFS_HS_BEGIN    8'h35
`define DGSP_OFS_HS_END      8'h36
`define DGSP_OFS_POLARITY    8'h37
`define DGSP_OFS_RESAMPLE    8'h44
`define DGSP_RST_MODE_CTL    8'hce
`define DGSP_RST_LUMA_GAIN1  8'hf0
`define DGSP_RST_SHADOW_HIGH 8'h70
`define DGSP_RST_SHADOW_LOW  8'h00
`define DGSP_RST_MISC_GAIN   8'he3
`define DGSP_RST_HS_HIGH     8'h0f
`define DGSP_RST_HS_BEGIN    8'h01
`define DGSP_RST_HS_END      8'h00
`define DGSP_RST_POLARITY    8'h00
`define DGSP_RST_RESAMPLE    8'h01
`define DGSP_BIT_PEAK_WHITE_UPDATE_RATE      0
`define DGSP_BIT_AVG_LINES   1
`define DGSP_BIT_COLOR_KILL  6
`define DGSP_BIT_SURV_EN     7
`define DGSP_BIT_LOCK_INV    6
`define DGSP_AVG_FIRST_LINE  10'd33
`define DGSP_AVG_LAST_LONG   10'd310
`define DGSP_AVG_LAST_SHORT  10'd270
`define DGSP_CLK_HZ          125000000
`define DGSP_TC_SLOW_MS      2000
`define DGSP_TC_MED_MS       1000
`define DGSP_TC_FAST_MS      200
`define DGSP_GAIN_STEP_MAX   12'h001
`endif

// ==== hdl/dgsp_pkg.sv ====
// Types of the gain, sync position and polarity control bank.
// Assumes the offsets in dgsp_regs.svh.
package dgsp_pkg;
  typedef enum logic [2:0] {
    LGM_MANUAL   = 3'b000,
    LGM_NOOVR_A  = 3'b001,
    LGM_AUTOOVR  = 3'b010,
    LGM_NOOVR_B  = 3'b011,
    LGM_AUTOOVR2 = 3'b100,
    LGM_PEAK     = 3'b101,
    LGM_AVERAGE  = 3'b110,
    LGM_FREEZE   = 3'b111
  } dgsp_gain_mode_t;

  typedef enum logic [1:0] {
    TRK_SLOW    = 2'b00,
    TRK_MEDIUM  = 2'b01,
    TRK_FAST    = 2'b10,
    TRK_QUALITY = 2'b11
  } dgsp_track_t;

  typedef struct packed {
    logic clkOut;
    logic clkHalf;
    logic qualClk;
    logic fifoHalf;
    logic fifoEmpty;
    logic fifoFull;
    logic dataValid;
    logic fieldSync;
    logic lineRef;
    logic vsync;
    logic hrefWin;
    logic vrefWin;
  } dgsp_video_t;

  typedef struct packed {
    logic       measPulse;
    logic [8:0] ireCeilPal;
    logic [8:0] ireCeilNtsc;
    logic       colorKill;
    logic       lockBit;
  } dgsp_ctl_t;
endpackage : dgsp_pkg

// ==== bench/dgsp_ctrl_asserts.sv ====
// Checker of the gain, sync and polarity bank, bound to dgsp_ctrl.
// clkEn may drop only while inputs rest; shadows 0x34..0x37 writes.
`timescale 1ns/100ps
module dgsp_ctrl_asserts (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  clkEn,
  input wire logic [7:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  intHsyncFall,
  input wire dgsp_pkg::dgsp_video_t rawVideo,
  input wire dgsp_pkg::dgsp_video_t outVideo_ff,
  input wire logic                  hsyncOut_ff,
  input wire logic [11:0]           gainInUse_ff
);
  logic [7:0]  regS_ff [4];
  logic [10:0] px_ff;
  logic        polD_ff, take, act;
  logic [9:0]  hsync_begin_offset, hsync_end_offset;
  logic [3:0]  polRev;
  assign take = clkEn & (avs_read | avs_write) & avs_waitrequest;
  assign hsync_begin_offset = {regS_ff[0][7:6], regS_ff[1]};
  assign hsync_end_offset = {regS_ff[0][5:4], regS_ff[2]};
  assign polRev = {regS_ff[3][2], regS_ff[3][3],
                   regS_ff[3][4], regS_ff[3][5]};
  // Output register lags the polarity bit by one cycle
  assign act = hsyncOut_ff ^ polD_ff;
  always_ff @(posedge clk) begin
    if (!rst_b)
      regS_ff <= '{8'h0f, 8'h01, 8'h00, 8'h00};
    else if (take && avs_write && avs_byteenable[0] &&
             avs_address[7:2] == 6'h0d)
      regS_ff[avs_address[1:0]] <= avs_writedata[7:0];
  end
  always_ff @(posedge clk) begin
    if (!rst_b)
      px_ff <= 11'h0;
    else if (intHsyncFall)
      px_ff <= 11'h1;
    else if (px_ff != 11'h0 && px_ff != 11'h7ff)
      px_ff <= px_ff + 11'h1;
  end
  always_ff @(posedge clk) polD_ff <= regS_ff[3][7];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack; take |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_rdg; take && avs_read && avs_address == 8'h32 |=>
    avs_readdata == {24'h0, $past(gainInUse_ff[7:0])}; endproperty
  a_rdg: assert property (p_rdg) else $error("gain readback");
  property p_hsb; px_ff == {1'b0, hsync_begin_offset} + 11'h2 && hsync_begin_offset != hsync_end_offset |->
    act && !$past(act); endproperty
  a_hsb: assert property (p_hsb) else $error("hsync start");
  property p_hse; px_ff == {1'b0, hsync_end_offset} + 11'h2 && hsync_end_offset > hsync_begin_offset |->
    !act && $past(act); endproperty
  a_hse: assert property (p_hse) else $error("hsync end");
  property p_clk; $past(rst_b) |-> outVideo_ff[11:9] ==
    ($past(rawVideo[11:9]) ^ {3{$past(regS_ff[3][0])}}); endproperty
  a_clk: assert property (p_clk) else $error("clock polarity");
  property p_ffl; $past(rst_b) |-> outVideo_ff[8:6] ==
    ($past(rawVideo[8:6]) ^ {3{$past(regS_ff[3][1])}}); endproperty
  a_ffl: assert property (p_ffl) else $error("flag polarity");
  property p_sig; $past(rst_b) |-> outVideo_ff[5:2] ==
    ($past(rawVideo[5:2]) ^ $past(polRev)); endproperty
  a_sig: assert property (p_sig) else $error("sync pol");
  property p_win; $past(rst_b) |-> outVideo_ff[1:0] ==
    ($past(rawVideo[1:0]) ^ {2{$past(regS_ff[3][6])}}); endproperty
  a_win: assert property (p_win) else $error("window polarity");
endmodule : dgsp_ctrl_asserts
bind dgsp_ctrl dgsp_ctrl_asserts u_dgsp_ctrl_asserts (.clk, .rst_b,
  .clkEn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .intHsyncFall,
  .rawVideo, .outVideo_ff, .hsyncOut_ff, .gainInUse_ff);

// ==== bench/dgsp_video_sink.sv ====
// Downstream video back-end: measures where the placed hsync starts
// and how long it lasts, counted from the internal hsync fall.
`timescale 1ns/100ps
module dgsp_video_sink (
  input wire logic   clk,
  input wire logic   rst_b,
  input wire logic   lineFall,
  input wire logic   hsync,
  input wire logic   activeLow,
  output logic [10:0] hsStart_ff,
  output logic [10:0] hsWidth_ff
);
  logic [10:0] px_ff;
  logic        on;
  assign on = hsync ^ activeLow;
  always_ff @(posedge clk) begin
    if (!rst_b || lineFall) begin
      px_ff <= 11'h0;
      hsStart_ff <= 11'h0;
      hsWidth_ff <= 11'h0;
    end else begin
      px_ff <= px_ff + 11'h1;
      if (on && hsStart_ff == 11'h0)
        hsStart_ff <= px_ff + 11'h1;
      if (on)
        hsWidth_ff <= hsWidth_ff + 11'h1;
    end
  end
endmodule : dgsp_video_sink

// ==== bench/test_dgsp_ctrl.sv ====
// Self-checking bench of the gain, sync and polarity bank.
// Assumes the bound checker and the video back-end model beside it.
`timescale 1ns/100ps
module test_dgsp_ctrl;
  logic        clk, rst_b, clkEn, avs_read, avs_write, avs_waitrequest;
  logic        intHsyncFall, lineStart, fieldStart, rawLockBit;
  logic        hsyncOut_ff, hsPol;
  logic [7:0]  avs_address, rd;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rsp;
  logic [9:0]  lineNum;
  logic [11:0] measGainTarget, videoQuality, gainInUse_ff;
  logic [10:0] hsStart, hsWidth;
  dgsp_pkg::dgsp_video_t rawVideo, outVideo_ff;
  dgsp_pkg::dgsp_ctl_t   ctlOut_ff;
  int          errors = 0, checks_done = 0, cyc = 0;
  dgsp_ctrl u_dgsp_ctrl (.clk, .rst_b, .clkEn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .intHsyncFall, .lineStart,
    .fieldStart, .lineNum, .measGainTarget, .videoQuality, .rawVideo,
    .rawLockBit, .outVideo_ff, .hsyncOut_ff, .ctlOut_ff, .gainInUse_ff);
  dgsp_video_sink u_dgsp_video_sink (.clk, .rst_b, .lineFall(intHsyncFall),
    .hsync(hsyncOut_ff), .activeLow(hsPol), .hsStart_ff(hsStart),
    .hsWidth_ff(hsWidth));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    // Only the bench timeout ends a wait that never gets its answer
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask : rdchk
  task automatic evt(input logic [9:0] n, input logic f, input logic p,
                     input logic [11:0] e);
    @(posedge clk);
    lineNum <= n;
    lineStart <= !f;
    fieldStart <= f;
    @(posedge clk);
    lineStart <= 1'b0;
    fieldStart <= 1'b0;
    // The measurement strobe stands for this one cycle only
    @(posedge clk);
    chk({31'h0, ctlOut_ff.measPulse}, {31'h0, p});
    repeat (2) @(posedge clk);
    chk({20'h0, gainInUse_ff}, {20'h0, e});
  endtask : evt
  task automatic t_reset;
    logic [7:0] ofs [9] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
                            8'h37, 8'h44, 8'h2c};
    logic [7:0] rv [9] = '{8'h74, 8'h00, 8'he3, 8'h0f, 8'h01, 8'h00,
                           8'h00, 8'h01, 8'hce};
    for (int i = 0; i < 9; i++)
      rdchk(ofs[i], rv[i]);
    rdchk(8'h40, 8'h00);
    chk({30'h0, rsp}, {30'h0, 2'b11});
    avs_byteenable <= 4'he;
    bus(1'b1, 8'h36, 8'h55);
    avs_byteenable <= 4'hf;
    rdchk(8'h36, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_gain;
    bus(1'b1, 8'h2c, 8'hfc);
    bus(1'b1, 8'h31, 8'h72);
    bus(1'b1, 8'h32, 8'h5a);
    repeat (3) @(posedge clk);
    chk({20'h0, gainInUse_ff}, 32'h400);
    rdchk(8'h31, 8'h74);
    bus(1'b1, 8'h2c, 8'h8c);
    repeat (3) @(posedge clk);
    chk({20'h0, gainInUse_ff}, 32'h25a);
    rdchk(8'h32, 8'h5a);
    bus(1'b1, 8'h2c, 8'hfc);
    bus(1'b1, 8'h31, 8'hf1);
    bus(1'b1, 8'h32, 8'h33);
    repeat (3) @(posedge clk);
    chk({20'h0, gainInUse_ff}, 32'h133);
    $display("test gain done");
  endtask : t_gain
  task automatic t_auto;
    measGainTarget <= 12'h200;
    bus(1'b1, 8'h33, 8'ha0);
    bus(1'b1, 8'h2c, 8'hec);
    evt(10'h12c, 1'b0, 1'b1, 12'h134);
    evt(10'h12c, 1'b1, 1'b0, 12'h134);
    bus(1'b1, 8'h33, 8'ha1);
    evt(10'h12c, 1'b0, 1'b0, 12'h134);
    evt(10'h12c, 1'b1, 1'b1, 12'h135);
    bus(1'b1, 8'h33, 8'ha2);
    evt(10'h12c, 1'b0, 1'b0, 12'h135);
    evt(10'h10e, 1'b0, 1'b1, 12'h136);
    evt(10'h021, 1'b0, 1'b1, 12'h137);
    evt(10'h020, 1'b0, 1'b0, 12'h137);
    $display("test auto done");
  endtask : t_auto
  task automatic t_track;
    logic [11:0] g;
    // Quality-led tracking steps once per videoQuality + 2 cycles
    videoQuality <= 12'h00e;
    bus(1'b1, 8'h2c, 8'hac);
    repeat (2) @(posedge clk);
    g = gainInUse_ff;
    repeat (64) @(posedge clk);
    chk({20'h0, gainInUse_ff}, {20'h0, g + 12'h004});
    // A low clock enable must freeze the running loop
    clkEn <= 1'b0;
    @(posedge clk);
    g = gainInUse_ff;
    repeat (64) @(posedge clk);
    chk({20'h0, gainInUse_ff}, {20'h0, g});
    clkEn <= 1'b1;
    $display("test tracking done");
  endtask : t_track
  task automatic t_ire;
    logic [8:0] palT [8] = '{9'h85, 9'h7d, 9'h78, 9'h73, 9'h6e, 9'h69,
                             9'h64, 9'h64};
    logic [8:0] ntT [8] = '{9'h7a, 9'h73, 9'h6e, 9'h69, 9'h64, 9'h64,
                            9'h64, 9'h64};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h33, {1'b1, i[0], 1'b1, i[2:0], 2'b00});
      repeat (3) @(posedge clk);
      chk({13'h0, ctlOut_ff.ireCeilPal, ctlOut_ff.ireCeilNtsc,
           ctlOut_ff.colorKill}, {13'h0, palT[i], ntT[i], i[0]});
    end
    $display("test ire done");
  endtask : t_ire
  task automatic t_pol;
    logic [11:0] m [7] = '{12'he00, 12'h1c0, 12'h020, 12'h010, 12'h008,
                           12'h004, 12'h003};
    logic [11:0] x;
    for (int i = 0; i < 7; i++) begin
      x = 12'ha5c ^ 12'(i * 37);
      rawVideo <= x;
      bus(1'b1, 8'h37, 8'h01 << i);
      repeat (3) @(posedge clk);
      chk(32'(outVideo_ff), 32'(x ^ m[i]));
    end
    for (int i = 0; i < 4; i++) begin
      rawLockBit <= i[0];
      bus(1'b1, 8'h44, i[1] ? 8'h41 : 8'h01);
      repeat (3) @(posedge clk);
      chk({31'h0, ctlOut_ff.lockBit}, {31'h0, i[0] ^ i[1]});
    end
    $display("test polarity done");
  endtask : t_pol
  task automatic t_hsync;
    bus(1'b1, 8'h34, 8'h5f);
    bus(1'b1, 8'h35, 8'h05);
    bus(1'b1, 8'h36, 8'ha0);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h37, p[0] ? 8'h80 : 8'h00);
      hsPol <= p[0];
      @(posedge clk);
      intHsyncFall <= 1'b1;
      @(posedge clk);
      intHsyncFall <= 1'b0;
      // Let the line run out so the idle level takes the next polarity
      repeat (1040) @(posedge clk);
      chk({21'h0, hsStart}, 32'h107);
      chk({21'h0, hsWidth}, 32'h09b);
    end
    $display("test hsync done");
  endtask : t_hsync
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      results();
    end
  end
  initial begin
    {rst_b, avs_read, avs_write, intHsyncFall, lineStart, fieldStart} = '0;
    {rawLockBit, hsPol, avs_address, avs_writedata, lineNum} = '0;
    clkEn = 1'b1;
    avs_byteenable = 4'hf;
    measGainTarget = 12'h000;
    videoQuality = 12'h000;
    rawVideo = 12'h000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_gain();
    t_auto();
    t_track();
    t_ire();
    t_pol();
    t_hsync();
    results();
  end
endmodule : test_dgsp_ctrl
